// file: verilog/ext_read_status.sv
// Purpose: Extended read status register behind the serial command port.
// Assumes: SPI mode 0, single I/O; the array engine reports each finished
//          operation with a one-cycle op_done_i and its outcome bits.
// Notes: Serial pins are oversampled by clk_i; sck must stay below clk/6.
`timescale 1ns/1ns
module ext_read_status
   import ext_status_pkg::*;
#(
   parameter int NV_ERASE_CYCLES = ext_status_pkg::NV_ERASE_CYC,
   parameter int NV_PROG_CYCLES = ext_status_pkg::NV_PROG_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic soft_rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_n_o,
   input wire logic status_busy_i,
   input wire logic write_enable_latch_i,
   input wire logic [3:0] block_protect_bits_i,
   input wire logic status_write_disable_i,
   input wire logic wp_n_i,
   input wire logic op_done_i,
   input wire ext_status_pkg::op_kind_e op_kind_i,
   input wire logic op_fail_i,
   input wire logic op_protected_i,
   input wire logic erase_step_fail_i,
   input wire logic prog_step_fail_i,
   output logic [7:0] ext_status_o,
   output logic [2:0] drive_sel_o,
   output logic [3:0] drive_eighths_o,
   output logic drive_active_o,
   output logic nv_busy_o
);
   import ext_status_pkg::*;

   initial begin
      if (NV_ERASE_CYCLES < 1 || NV_PROG_CYCLES < 1 ||
          NV_ERASE_CYCLES > 65535 || NV_PROG_CYCLES > 65535) begin
         $error("nonvolatile step counts out of range");
      end
   end

   // ================================================================
   // Pin synchronisers
   logic [1:0] sck_sync_q, cs_sync_q, si_sync_q, wp_sync_q;
   logic sck_prev_q, cs_prev_q;
   always_ff @(posedge clk_i) begin
      sck_sync_q <= {sck_sync_q[0], sck_i};
      cs_sync_q <= {cs_sync_q[0], cs_n_i};
      si_sync_q <= {si_sync_q[0], si_i};
      wp_sync_q <= {wp_sync_q[0], wp_n_i};
      sck_prev_q <= sck_sync_q[1];
      cs_prev_q <= cs_sync_q[1];
   end
   wire sck_rise = sck_sync_q[1] & ~sck_prev_q & ~cs_sync_q[1];
   wire sck_fall = ~sck_sync_q[1] & sck_prev_q & ~cs_sync_q[1];
   wire frame_end = cs_sync_q[1] & ~cs_prev_q;

   // ================================================================
   // Drive strength decode
   function automatic logic ds_valid(input logic [2:0] code);
      ds_valid = (code != DS_RSVD_A) && (code != DS_RSVD_B);
   endfunction

   function automatic logic [3:0] ds_eighths(input logic [2:0] code);
      case (code)
         3'h1: ds_eighths = 4'h1;
         3'h2: ds_eighths = 4'h2;
         3'h3: ds_eighths = 4'h3;
         3'h5: ds_eighths = 4'h6;
         3'h6: ds_eighths = 4'h8;
         3'h7: ds_eighths = 4'h4;
         default: ds_eighths = 4'h0;
      endcase
   endfunction

   // ================================================================
   // Serial shifter
   logic [4:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] opcode_q, data_q, shift_q;
   wire [7:0] shift_next = {shift_q[6:0], si_sync_q[1]};
   always_comb begin
      bit_cnt_d = bit_cnt_q;
      if (cs_sync_q[1]) begin
         bit_cnt_d = 5'h00;
      end else if (sck_rise && bit_cnt_q != BITS_SAT) begin
         bit_cnt_d = bit_cnt_q + 5'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bit_cnt_q <= 5'h00;
         shift_q <= 8'h00;
         opcode_q <= 8'h00;
         data_q <= 8'h00;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         if (sck_rise) begin
            shift_q <= shift_next;
         end
         if (sck_rise && bit_cnt_q == OPCODE_BITS - 5'h01) begin
            opcode_q <= shift_next;
         end
         if (sck_rise && bit_cnt_q == WRITE_BITS - 5'h01) begin
            data_q <= shift_next;
         end
      end
   end

   // ================================================================
   // Command decode; writes and clear at frame end, read while the frame runs
   wire len_wr = bit_cnt_q == WRITE_BITS;
   wire new_ds_ok = ds_valid(data_q[DS_HI_POS:DS_LO_POS]);
   // Reserved drive codes are dropped so the pads never see them
   wire wr_allowed = frame_end & len_wr & write_enable_latch_i;
   wire wr_vol = wr_allowed & (opcode_q == OP_SET_EXT_V)
      & new_ds_ok;
   wire wr_nv_req = wr_allowed & (opcode_q == OP_SET_EXT_NV)
      & new_ds_ok;
   wire clr_cmd = frame_end & (bit_cnt_q == OPCODE_BITS)
      & (opcode_q == OP_CLEAR_EXT);
   wire rd_active = ~cs_sync_q[1] & (bit_cnt_q >= OPCODE_BITS)
      & (opcode_q == OP_READ_EXT);

   // ================================================================
   // Nonvolatile update sequencer
   nv_state_e nv_state_q, nv_state_d;
   logic [15:0] nv_cnt_q, nv_cnt_d;
   logic [2:0] nv_ds_q, nv_pend_q;
   wire nv_start = wr_nv_req & (nv_state_q == NV_IDLE);
   wire nv_step_end = nv_cnt_q == 16'h0000;
   wire nv_erase_bad = (nv_state_q == NV_ERASE) & nv_step_end
      & erase_step_fail_i;
   wire nv_prog_bad = (nv_state_q == NV_PROG) & nv_step_end
      & prog_step_fail_i;
   wire nv_commit = (nv_state_q == NV_PROG) & nv_step_end
      & ~prog_step_fail_i;
   always_comb begin
      nv_state_d = nv_state_q;
      nv_cnt_d = nv_step_end ? nv_cnt_q : nv_cnt_q - 16'h0001;
      case (nv_state_q)
         NV_IDLE: begin
            if (nv_start) begin
               nv_state_d = NV_ERASE;
               nv_cnt_d = 16'(NV_ERASE_CYCLES - 1);
            end
         end
         NV_ERASE: begin
            // A failed erase step aborts; programming would be meaningless
            if (nv_step_end && erase_step_fail_i) begin
               nv_state_d = NV_IDLE;
            end else if (nv_step_end) begin
               nv_state_d = NV_PROG;
               nv_cnt_d = 16'(NV_PROG_CYCLES - 1);
            end
         end
         NV_PROG: begin
            if (nv_step_end) begin
               nv_state_d = NV_IDLE;
            end
         end
         default: nv_state_d = NV_IDLE;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         nv_state_q <= NV_IDLE;
         nv_cnt_q <= 16'h0000;
         nv_pend_q <= DS_DEFAULT;
         nv_ds_q <= DS_DEFAULT;
      end else begin
         nv_state_q <= nv_state_d;
         nv_cnt_q <= nv_cnt_d;
         if (nv_start) begin
            nv_pend_q <= data_q[DS_HI_POS:DS_LO_POS];
         end
         if (nv_commit) begin
            nv_ds_q <= nv_pend_q;
         end
      end
   end

   // ================================================================
   // Volatile drive strength
   logic [2:0] vol_ds_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         vol_ds_q <= DS_DEFAULT;
      end else if (soft_rst_i) begin
         vol_ds_q <= nv_ds_q;
      end else if (wr_vol) begin
         vol_ds_q <= data_q[DS_HI_POS:DS_LO_POS];
      end
   end

   // ================================================================
   // Error flag setting from finished operations
   // Flags never gate any command; nothing here feeds the decoder.
   wire is_prog = op_kind_i == OPK_PROGRAM;
   wire is_irp = op_kind_i == OPK_INFO_PROGRAM;
   wire is_erase = op_kind_i == OPK_ERASE;
   wire is_cer = op_kind_i == OPK_CHIP_ERASE;
   wire is_write_status_cmd = op_kind_i == OPK_WRITE_STATUS;
   wire is_write_autoboot_cmd = op_kind_i == OPK_WRITE_AUTOBOOT;
   wire is_write_function_cmd = op_kind_i == OPK_WRITE_FUNCTION;
   wire sr_locked = status_write_disable_i & ~wp_sync_q[1];
   wire cer_bp = is_cer & (block_protect_bits_i != 4'h0);
   wire prog_prot = (is_prog | is_irp)
      & op_protected_i;
   wire erase_prot = ((is_erase | is_cer) & op_protected_i)
      | cer_bp;
   wire write_status_cmd_prot = is_write_status_cmd & sr_locked;
   wire nv_reg_op = (is_write_status_cmd & ~sr_locked) | is_write_autoboot_cmd;
   wire set_prot = op_done_i
      & (prog_prot | erase_prot | write_status_cmd_prot);
   wire set_perr = (op_done_i & (((is_prog | is_irp) & op_fail_i)
      | prog_prot | (nv_reg_op & prog_step_fail_i)))
      | nv_prog_bad;
   // OTP clear attempts are not failures, so op_fail_i stays low for them
   wire set_perr_fn = op_done_i & is_write_function_cmd
      & op_fail_i;
   wire set_eerr = (op_done_i & (((is_erase | is_cer) & op_fail_i)
      | erase_prot | write_status_cmd_prot | (nv_reg_op & erase_step_fail_i)))
      | nv_erase_bad;

   logic eerr_q, perr_q, prot_q;
   wire clr_any = clr_cmd | soft_rst_i;
   // Set beats clear so a fault landing on the clear is still reported
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         eerr_q <= 1'b0;
         perr_q <= 1'b0;
         prot_q <= 1'b0;
      end else begin
         eerr_q <= (eerr_q & ~clr_any) | set_eerr;
         perr_q <= (perr_q & ~clr_any) | set_perr | set_perr_fn;
         prot_q <= (prot_q & ~clr_any) | set_prot;
      end
   end

   // ================================================================
   // Register image and readout
   wire write_in_progress = status_busy_i | (nv_state_q != NV_IDLE);
   wire [7:0] reg_val = {vol_ds_q, 1'b1, eerr_q, perr_q, prot_q,
      write_in_progress};

   logic [7:0] tx_q, stat_q;
   logic [2:0] tx_cnt_q;
   logic so_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || cs_sync_q[1]) begin
         tx_q <= 8'h00;
         tx_cnt_q <= 3'h0;
         so_q <= 1'b0;
      end else if (sck_fall && rd_active) begin
         // A fresh snapshot each byte lets software poll busy in one frame
         tx_cnt_q <= tx_cnt_q + 3'h1;
         if (tx_cnt_q == 3'h0) begin
            so_q <= reg_val[7];
            tx_q <= {reg_val[6:0], 1'b0};
         end else begin
            so_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         stat_q <= EXT_RESET;
      end else begin
         stat_q <= reg_val;
      end
   end

   assign so_o = so_q;
   assign so_oe_n_o = ~rd_active;
   assign ext_status_o = stat_q;
   assign drive_sel_o = vol_ds_q;
   assign drive_eighths_o = ds_eighths(vol_ds_q);
   assign drive_active_o = rd_active;
   assign nv_busy_o = nv_state_q != NV_IDLE;

   // ================================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_flag_sticky: assert property (eerr_q && !clr_any |=> eerr_q)
      else $error("erase error dropped without clear");
   a_clear_works: assert property (clr_cmd && !set_prot |=> !prot_q)
      else $error("protection error survived clear");
   a_cer_bp_flags: assert property (op_done_i && cer_bp
      |=> eerr_q && prot_q)
      else $error("chip erase under protection not flagged");
   a_write_status_cmd_locked: assert property (op_done_i && write_status_cmd_prot
      |=> prot_q && eerr_q)
      else $error("locked status write not flagged");
   a_pp_prot: assert property (op_done_i && is_prog && op_protected_i
      |=> perr_q && prot_q)
      else $error("protected program not flagged");
   a_rsvd_one: assert property (ext_status_o[RSVD_POS])
      else $error("reserved bit not one");
   a_wip_mirror: assert property (status_busy_i |=> ext_status_o[WIP_POS])
      else $error("busy not mirrored");
   a_no_wel_write: assert property (!write_enable_latch_i
      |=> $stable(vol_ds_q) || $past(soft_rst_i))
      else $error("write taken without write enable");
   a_ds_never_rsvd: assert property (ds_valid(vol_ds_q))
      else $error("reserved drive code active");
   a_nv_seq_len: assert property (nv_start
      |-> ##1 (nv_state_q == NV_ERASE) [*2])
      else $error("nonvolatile erase step too short");
   a_vol_write: assert property (wr_vol && !soft_rst_i
      |=> vol_ds_q == $past(data_q[7:5]))
      else $error("volatile write lost");

   c_vol_write: cover property (wr_vol);
   c_nv_commit: cover property (nv_commit);
   c_clear: cover property (clr_cmd && eerr_q);
   c_read: cover property (rd_active && sck_fall);
endmodule

// file: verilog/ext_status_pkg.sv
// Purpose: Constants and types for the extended read status register.
// Assumes: Single-I/O SPI framing, 50 MHz system clock.
// Notes: Opcodes 81h and 82h and nonvolatile step times are local.
package ext_status_pkg;
   // ================================================================
   // Opcodes
   localparam logic [7:0] OP_SET_EXT_NV = 8'h85;
   localparam logic [7:0] OP_SET_EXT_V = 8'h83;
   localparam logic [7:0] OP_READ_EXT = 8'h81;
   localparam logic [7:0] OP_CLEAR_EXT = 8'h82;
   // ================================================================
   // Register layout and reset value
   localparam logic [7:0] EXT_RESET = 8'hf0;
   localparam int DS_HI_POS = 7;
   localparam int DS_LO_POS = 5;
   localparam int RSVD_POS = 4;
   localparam int ERASE_ERR_POS = 3;
   localparam int PROG_ERR_POS = 2;
   localparam int PROT_ERR_POS = 1;
   localparam int WIP_POS = 0;
   localparam logic [2:0] DS_DEFAULT = 3'h7;
   localparam logic [2:0] DS_RSVD_A = 3'h0;
   localparam logic [2:0] DS_RSVD_B = 3'h4;
   // ================================================================
   // Frame lengths in serial bits
   localparam logic [4:0] OPCODE_BITS = 5'h08;
   localparam logic [4:0] WRITE_BITS = 5'h10;
   localparam logic [4:0] BITS_SAT = 5'h1f;
   // ================================================================
   // Nonvolatile update step times
   localparam int CLK_MHZ = 50;
   localparam int NV_ERASE_NS = 2000;
   localparam int NV_PROG_NS = 2000;
   localparam int NV_ERASE_CYC = NV_ERASE_NS * CLK_MHZ / 1000;
   localparam int NV_PROG_CYC = NV_PROG_NS * CLK_MHZ / 1000;
   // ================================================================
   // Kinds of completed array or register operation
   typedef enum logic [2:0] {
      OPK_PROGRAM,
      OPK_INFO_PROGRAM,
      OPK_ERASE,
      OPK_CHIP_ERASE,
      OPK_WRITE_STATUS,
      OPK_WRITE_AUTOBOOT,
      OPK_WRITE_FUNCTION,
      OPK_NONE
   } op_kind_e;
   typedef enum {NV_IDLE, NV_ERASE, NV_PROG} nv_state_e;
endpackage

// file: tb/ext_host_model.sv
// Purpose: Serial host that frames commands for the status block.
// Assumes: Mode 0, single I/O, clock low between frames.
// Notes: Half period 80 ns; frames start off the system clock edge.
`timescale 1ns/1ns
module ext_host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_n_i
);
   // ================================================================
   // Idle levels
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // ================================================================
   // One frame: opcode then data, bits beyond the opcode are read back
   task automatic frame(input logic [15:0] bits, input int n,
      output logic [7:0] rd, output logic oe_ok);
      oe_ok = 1'b1;
      rd = 8'h00;
      #7 cs_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_o = bits[15 - i];
         #80 sck_o = 1'b1;
         if (i >= 8) begin
            rd = {rd[6:0], so_i};
            if (so_oe_n_i !== 1'b0) oe_ok = 1'b0;
         end
         #80 sck_o = 1'b0;
      end
      #80 cs_n_o = 1'b1;
      // Released line toggles so a stale bit never looks valid
      si_o = ~si_o;
      #120;
   endtask
endmodule

// file: tb/flash_ext_read_status_register_tb_top.sv
// Purpose: Self-checking bench for the extended read status register.
// Assumes: Short nonvolatile steps (2 cycles each) to keep runs brief.
// Notes: Reference model tracks drive codes and flags in plain variables.
`timescale 1ns/1ns
module flash_ext_read_status_register_tb_top;
   import ext_status_pkg::*;
   // ================================================================
   // Signals
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic soft_rst_i = 1'b0;
   logic sck, cs_n, si, so, so_oe_n, drive_active, nv_busy;
   logic busy = 1'b0, write_enable_latch = 1'b0, status_write_disable = 1'b0, wp_n = 1'b1;
   logic [3:0] bp = 4'h0;
   logic op_done = 1'b0, fail = 1'b0, prot = 1'b0, esf = 1'b0, psf = 1'b0;
   op_kind_e kind = OPK_NONE;
   logic [7:0] ext_status, rd, d;
   logic [2:0] drive_sel;
   logic [3:0] drive_eighths;
   logic oe_ok;
   logic [2:0] m_vol = 3'h7, m_nv = 3'h7;
   logic m_e = 1'b0, m_p = 1'b0, m_pr = 1'b0;
   logic [31:0] r;
   logic f, pt, lk, bz;
   int seed = 28;
   int miscompares = 0;
   int comparisons = 0;
   int eighths_tab[8] = '{0, 1, 2, 3, 0, 6, 8, 4};
   always #10 clk_i = ~clk_i;
   // ================================================================
   // Instances
   ext_read_status #(.NV_ERASE_CYCLES(2), .NV_PROG_CYCLES(2)) i_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
      .so_oe_n_o(so_oe_n), .status_busy_i(busy),
      .write_enable_latch_i(write_enable_latch), .block_protect_bits_i(bp),
      .status_write_disable_i(status_write_disable), .wp_n_i(wp_n), .op_done_i(op_done),
      .op_kind_i(kind), .op_fail_i(fail), .op_protected_i(prot),
      .erase_step_fail_i(esf), .prog_step_fail_i(psf),
      .ext_status_o(ext_status), .drive_sel_o(drive_sel),
      .drive_eighths_o(drive_eighths), .drive_active_o(drive_active),
      .nv_busy_o(nv_busy));
   ext_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
      .so_i(so), .so_oe_n_i(so_oe_n));
   // ================================================================
   // Checking and transfer tasks
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] seen);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_all();
      repeat (3) @(posedge clk_i);
      #1;
      check("ext_status", {m_vol, 1'b1, m_e, m_p, m_pr, busy}, ext_status);
      check("drive_sel", {5'h00, m_vol}, {5'h00, drive_sel});
      check("drive_eighths", 8'(eighths_tab[m_vol]), {4'h0, drive_eighths});
   endtask
   task automatic send(input logic [7:0] op, input logic [7:0] dt,
      input int n);
      @(posedge clk_i);
      u_host.frame({op, dt}, n, rd, oe_ok);
      repeat (4) @(posedge clk_i);
   endtask
   task automatic read_reg();
      send(OP_READ_EXT, 8'h00, 16);
      check("read_data", {m_vol, 1'b1, m_e, m_p, m_pr, busy}, rd);
      check("read_oe", 8'h01, {7'h00, oe_ok});
   endtask
   task automatic nv_write(input logic [7:0] dt);
      write_enable_latch <= 1'b1;
      send(OP_SET_EXT_NV, dt, 16);
      for (int i = 0; i < 60 && nv_busy !== 1'b0; i++) @(posedge clk_i);
      if (nv_busy !== 1'b0) begin
         miscompares++;
         final_report();
      end
   endtask
   // ================================================================
   // Watchdog
   initial begin
      #1500000;
      miscompares++;
      final_report();
   end
   // ================================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check_all();
      for (int c = 0; c < 8; c++) begin
         d = {3'(c), 5'($random(seed))};
         write_enable_latch <= 1'b1;
         send(OP_SET_EXT_V, d, 16);
         if (c != 0 && c != 4) m_vol = 3'(c);
         check_all();
         read_reg();
      end
      write_enable_latch <= 1'b0;
      send(OP_SET_EXT_V, 8'h3f, 16);
      check_all();
      write_enable_latch <= 1'b1;
      send(OP_SET_EXT_V, 8'h3f, 15);
      check_all();
      nv_write(8'h5f);
      m_nv = 3'h2;
      check_all();
      @(posedge clk_i);
      soft_rst_i <= 1'b1;
      @(posedge clk_i);
      soft_rst_i <= 1'b0;
      m_vol = m_nv;
      check_all();
      esf <= 1'b1;
      nv_write(8'h40);
      esf <= 1'b0;
      m_e = 1'b1;
      check_all();
      psf <= 1'b1;
      nv_write(8'h40);
      psf <= 1'b0;
      m_p = 1'b1;
      check_all();
      send(OP_CLEAR_EXT, 8'h00, 8);
      {m_e, m_p} = 2'b00;
      check_all();
      for (int i = 0; i < 48; i++) begin
         r = $random(seed);
         kind = op_kind_e'(r[10:8]);
         f = r[11] & (kind != OPK_WRITE_STATUS) & (kind != OPK_WRITE_AUTOBOOT);
         pt = r[12] & (kind < OPK_WRITE_STATUS);
         @(posedge clk_i);
         bp <= r[3:0] & {4{r[4]}};
         status_write_disable <= r[5];
         wp_n <= r[6];
         busy <= r[7];
         repeat (3) @(posedge clk_i);
         op_done <= 1'b1;
         fail <= f;
         prot <= pt;
         esf <= r[13];
         psf <= r[14];
         @(posedge clk_i);
         op_done <= 1'b0;
         lk = r[5] & ~r[6];
         bz = |(r[3:0] & {4{r[4]}});
         case (kind)
            OPK_PROGRAM, OPK_INFO_PROGRAM: begin
               m_p |= f | pt;
               m_pr |= pt;
            end
            OPK_ERASE: begin
               m_e |= f | pt;
               m_pr |= pt;
            end
            OPK_CHIP_ERASE: begin
               m_e |= f | pt | bz;
               m_pr |= pt | bz;
            end
            OPK_WRITE_STATUS: begin
               m_e |= r[13] | lk;
               // A locked status write never starts the update steps
               m_p |= r[14] & ~lk;
               m_pr |= lk;
            end
            OPK_WRITE_AUTOBOOT: begin
               m_e |= r[13];
               m_p |= r[14];
            end
            OPK_WRITE_FUNCTION: m_p |= f;
            default: ;
         endcase
         check_all();
         if (i % 6 == 4) begin
            d = {3'(i % 3 + 1), 5'h1f};
            send(OP_SET_EXT_V, d, 16);
            m_vol = d[7:5];
            read_reg();
         end
         if (i % 6 == 5) begin
            send(OP_CLEAR_EXT, 8'h00, 8);
            {m_e, m_p, m_pr} = 3'b000;
            check_all();
         end
      end
      m_e = 1'b1;
      kind = OPK_ERASE;
      @(posedge clk_i);
      op_done <= 1'b1;
      fail <= 1'b1;
      @(posedge clk_i);
      op_done <= 1'b0;
      check_all();
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      {m_e, m_p, m_pr} = 3'b000;
      m_vol = 3'h7;
      check_all();
      final_report();
   end
endmodule
